// ---- sysio_defs.vh ----
// Purpose: constants for the shared system pin multiplexer
// Assumes: 32-bit AXI4-Lite data, 6-bit byte address
// Notes:   offsets are byte addresses
`ifndef SYSIO_DEFS_VH
`define SYSIO_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define SEL_OFS        6'h00
`define STATUS_OFS     6'h04
`define CTRL_OFS       6'h08
`define PAD_OFS        6'h0C

// ****************************************
// select bit positions and reset values
// ****************************************
`define SEL_TDI_BIT    4
`define SEL_TDO_BIT    5
`define SEL_TMS_BIT    6
`define SEL_TCK_BIT    7
`define SEL_DM_BIT     10
`define SEL_DP_BIT     11
`define SEL_ERASE_BIT  12
`define SEL_RESET      13'h0000
`define PAD_RESET      28'h0000000

// ****************************************
// status and control fields
// ****************************************
`define ST_SWD_BIT     0
`define ST_BSCAN_BIT   1
`define ST_FPROG_BIT   2
`define ST_ERASE_BIT   3
`define ST_XRST_BIT    4
`define ST_DRIVE_BIT   5
`define ST_EPIN_BIT    6
`define CTRL_RST_BIT   0

// ****************************************
// timing and bus response codes
// ****************************************
`define SLOW_CLK_HZ    32768
`define ERASE_MIN_MS   220
`define ERASE_IGN_MS   100
`define ERASE_TICKS    ((`ERASE_MIN_MS * `SLOW_CLK_HZ) / 1000)
`define EXTERNAL_RESET_LINE_PULSE_CYC 100
`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2

`endif

// ---- erase_debounce.v ----
// Purpose: debounce of the erase request on slow clock ticks
// Assumes: tick is a one-cycle pulse per slow clock period
// Notes:   fires once per continuous high period
`timescale 1ns/10ps
module erase_debounce #(
   parameter THRESH = 7209,
   parameter CNT_W  = 14
) (
   input  wire             aclk,
   input  wire             aresetn,
   input  wire             tick,
   input  wire             level,
   input  wire             enable,
   output reg              fire_q
);

   reg  [CNT_W-1:0] cnt_q;
   reg              done_q;

   // ****************************************
   // consecutive high count
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q  <= {CNT_W{1'b0}};
         done_q <= 1'b0;
         fire_q <= 1'b0;
      end else begin
         fire_q <= 1'b0;
         if (!level || !enable) begin
            // any low restarts the count; short highs vanish here
            cnt_q  <= {CNT_W{1'b0}};
            done_q <= 1'b0;
         end else if (tick && !done_q) begin
            if (cnt_q > THRESH[CNT_W-1:0]) begin
               fire_q <= 1'b1;
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // erase_debounce

// ---- sysio_mux.v ----
// Purpose: shared system pin multiplexer, debug and test selects,
//          bidirectional reset line and erase input
// Assumes: aclk 100 MHz; slow_clock and all pins are asynchronous
// Notes:   line index 0..6 = tdi, tdo, tms, tck, dm, dp, erase
`timescale 1ns/10ps
`include "sysio_defs.vh"
module sysio_mux #(
   parameter ERASE_TICKS = `ERASE_TICKS,
   parameter CNT_W       = 14,
   parameter EXTERNAL_RESET_LINE_CYC    = `EXTERNAL_RESET_LINE_PULSE_CYC,
   parameter EXTERNAL_RESET_LINE_W      = 16
) (
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite slave
   input  wire [5:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [5:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // shared pads
   input  wire [6:0]  pad_in,
   output reg  [6:0]  pad_out,
   output reg  [6:0]  pad_oe,
   output reg  [6:0]  pad_pull_up,
   output reg  [6:0]  pad_schmitt,
   output reg  [6:0]  pad_glitch,
   output reg  [6:0]  pad_debounce,
   // system function side
   input  wire [6:0]  sys_out,
   input  wire [6:0]  sys_oe,
   output reg  [6:0]  sys_in,
   input  wire        serial_wire_active,
   input  wire        async_trace_out,
   // port B side: lines 4,5,6,7,10,11,12
   input  wire [6:0]  pio_out,
   input  wire [6:0]  pio_oe,
   output reg  [6:0]  pio_in,
   // test pins
   input  wire        boundary_scan_select,
   input  wire        test_mode_select,
   output reg         boundary_scan_mode,
   output reg         bscan_test_mode,
   output reg         fast_prog_mode,
   // reset line
   input  wire        external_reset_line_in,
   output reg         external_reset_line_out,
   output reg         external_reset_line_oe,
   input  wire        reset_ctrl_req,
   output reg         core_reset_n,
   // erase
   input  wire        slow_clock,
   output reg         flash_erase_start
);

   localparam NP = 11;
   localparam TDO_IX = 1;

   // ****************************************
   // pin synchronisers
   // ****************************************
   wire [NP-1:0] raw;
   reg  [NP-1:0] s1_q;
   reg  [NP-1:0] s2_q;
   reg  [NP-1:0] s3_q;
   reg  [NP-1:0] lvl_q;

   assign raw = {slow_clock, external_reset_line_in,
                 test_mode_select, boundary_scan_select, pad_in};

   // a change counts only when the second and third stage agree
   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1) begin : g_sync
         always @(posedge aclk) begin
            if (!aresetn) begin
               // reset line idles high, so its filter starts high to avoid a false low
               s1_q[g]  <= (g == 9) ? 1'b1 : 1'b0;
               s2_q[g]  <= (g == 9) ? 1'b1 : 1'b0;
               s3_q[g]  <= (g == 9) ? 1'b1 : 1'b0;
               lvl_q[g] <= (g == 9) ? 1'b1 : 1'b0;
            end else begin
               s1_q[g] <= raw[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  lvl_q[g] <= s3_q[g];
               end
            end
         end
      end
   endgenerate

   wire [6:0] pin_lvl;
   wire       bscan_lvl;
   wire       tst_lvl;
   wire       external_reset_line_lvl;
   wire       slow_tick;

   assign pin_lvl   = lvl_q[6:0];
   assign bscan_lvl = lvl_q[7];
   assign tst_lvl   = lvl_q[8];
   assign external_reset_line_lvl  = lvl_q[9];
   assign slow_tick = s2_q[10] & ~s3_q[10];

   // ****************************************
   // registers
   // ****************************************
   reg  [12:0] sel_q;
   reg  [27:0] pad_q;
   reg         swd_q;
   reg         erase_seen_q;
   reg         xrst_seen_q;
   reg         sw_rst_q;

   reg         aw_full_q;
   reg         w_full_q;
   reg  [5:0]  aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;

   wire        do_write;
   wire        wr_sel;
   wire        wr_st;
   wire        wr_ctrl;
   wire        wr_pad;
   wire [31:0] st_word;

   assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign wr_sel   = do_write & (aw_addr_q == `SEL_OFS);
   assign wr_st    = do_write & (aw_addr_q == `STATUS_OFS);
   assign wr_ctrl  = do_write & (aw_addr_q == `CTRL_OFS);
   assign wr_pad   = do_write & (aw_addr_q == `PAD_OFS);

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   wire [31:0] sel_new;
   wire [31:0] pad_new;
   wire [31:0] clr_word;

   assign sel_new  = merge({19'h00000, sel_q}, w_data_q, w_strb_q);
   assign pad_new  = merge({4'h0, pad_q}, w_data_q, w_strb_q);
   assign clr_word = merge(32'h00000000, w_data_q, w_strb_q);

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `AXI_OKAY;
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         aw_addr_q     <= 6'h00;
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
         sel_q         <= `SEL_RESET;
         pad_q         <= `PAD_RESET;
         sw_rst_q      <= 1'b0;
      end else begin
         sw_rst_q <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_full_q     <= 1'b1;
            aw_addr_q     <= {s_axi_awaddr[5:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_full_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel | wr_st | wr_ctrl | wr_pad) ?
                            `AXI_OKAY : `AXI_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
         end
         if (wr_sel) begin
            sel_q <= sel_new[12:0];
         end
         if (wr_pad) begin
            pad_q <= pad_new[27:0];
         end
         if (wr_ctrl) begin
            sw_rst_q <= clr_word[`CTRL_RST_BIT];
         end
      end
   end

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   reg  [31:0] rd_word;
   reg  [1:0]  rd_resp;

   always @* begin
      rd_word = 32'h00000000;
      rd_resp = `AXI_OKAY;
      case ({s_axi_araddr[5:2], 2'b00})
         `SEL_OFS: begin
            rd_word = {19'h00000, sel_q};
         end
         `STATUS_OFS: begin
            rd_word = st_word;
         end
         `CTRL_OFS: begin
            rd_word = 32'h00000000;
         end
         `PAD_OFS: begin
            rd_word = {4'h0, pad_q};
         end
         default: begin
            rd_resp = `AXI_SLVERR;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `AXI_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_resp;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ****************************************
   // pin multiplexer
   // ****************************************
   wire [6:0] sel7;
   wire [6:0] gp;

   assign sel7 = {sel_q[`SEL_ERASE_BIT], sel_q[`SEL_DP_BIT],
                  sel_q[`SEL_DM_BIT],    sel_q[`SEL_TCK_BIT],
                  sel_q[`SEL_TMS_BIT],   sel_q[`SEL_TDO_BIT],
                  sel_q[`SEL_TDI_BIT]};
   // boundary scan keeps the debug pins in their system role
   assign gp = sel7 & ~{3'b000, {4{bscan_lvl}}};

   // trace only rides on tdo once serial wire is up
   wire trace_on;
   assign trace_on = swd_q & ~bscan_lvl;

   generate
      for (g = 0; g < 7; g = g + 1) begin : g_mux
         always @(posedge aclk) begin
            if (!aresetn) begin
               pad_out[g] <= 1'b0;
               pad_oe[g]  <= 1'b0;
               sys_in[g]  <= 1'b0;
               pio_in[g]  <= 1'b0;
            end else begin
               if (gp[g]) begin
                  pad_out[g] <= pio_out[g];
                  pad_oe[g]  <= pio_oe[g];
               end else if (g == TDO_IX && trace_on) begin
                  pad_out[g] <= async_trace_out;
                  pad_oe[g]  <= 1'b1;
               end else begin
                  pad_out[g] <= sys_out[g];
                  pad_oe[g]  <= sys_oe[g];
               end
               sys_in[g] <= gp[g] ? 1'b0 : pin_lvl[g];
               pio_in[g] <= pin_lvl[g];
            end
         end
      end
   endgenerate

   // pad setup is never gated by the select bits
   always @(posedge aclk) begin
      if (!aresetn) begin
         pad_pull_up  <= 7'h00;
         pad_schmitt  <= 7'h00;
         pad_glitch   <= 7'h00;
         pad_debounce <= 7'h00;
      end else begin
         pad_pull_up  <= pad_q[6:0];
         pad_schmitt  <= pad_q[13:7];
         pad_glitch   <= pad_q[20:14];
         pad_debounce <= pad_q[27:21];
      end
   end

   // ****************************************
   // debug and test mode
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         swd_q              <= 1'b0;
         boundary_scan_mode <= 1'b0;
         bscan_test_mode    <= 1'b0;
         fast_prog_mode     <= 1'b0;
      end else begin
         // the debug port core spots the host's switch sequence
         swd_q              <= serial_wire_active & ~bscan_lvl;
         boundary_scan_mode <= bscan_lvl;
         bscan_test_mode    <= tst_lvl & bscan_lvl;
         fast_prog_mode     <= tst_lvl & ~bscan_lvl;
      end
   end

   // ****************************************
   // bidirectional reset line
   // ****************************************
   reg [EXTERNAL_RESET_LINE_W-1:0] drv_cnt_q;
   wire             drv_req;

   assign drv_req = reset_ctrl_req | sw_rst_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         drv_cnt_q               <= {EXTERNAL_RESET_LINE_W{1'b0}};
         external_reset_line_out <= 1'b0;
         external_reset_line_oe  <= 1'b0;
         core_reset_n            <= 1'b1;
      end else begin
         external_reset_line_out <= 1'b0;
         if (drv_req) begin
            drv_cnt_q <= EXTERNAL_RESET_LINE_CYC[EXTERNAL_RESET_LINE_W-1:0];
         end else if (drv_cnt_q != {EXTERNAL_RESET_LINE_W{1'b0}}) begin
            drv_cnt_q <= drv_cnt_q - {{(EXTERNAL_RESET_LINE_W-1){1'b0}}, 1'b1};
         end
         // drive only while counting down, else leave it an input
         external_reset_line_oe <= drv_req |
                                   (drv_cnt_q > {{(EXTERNAL_RESET_LINE_W-1){1'b0}}, 1'b1});
         // core follows the line for as long as it is low; backup untouched
         core_reset_n <= external_reset_line_lvl;
      end
   end

   // ****************************************
   // erase input
   // ****************************************
   wire erase_fire;

   // monitor runs only in system mode, so a gpio high never erases
   erase_debounce #(
      .THRESH (ERASE_TICKS),
      .CNT_W  (CNT_W)
   ) u_erase (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (slow_tick),
      .level   (pin_lvl[6]),
      .enable  (~sel_q[`SEL_ERASE_BIT]),
      .fire_q  (erase_fire)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         flash_erase_start <= 1'b0;
         erase_seen_q      <= 1'b0;
         xrst_seen_q       <= 1'b0;
      end else begin
         flash_erase_start <= erase_fire;
         // a new event beats a clear in the same cycle
         erase_seen_q <= erase_fire |
                         (erase_seen_q & ~(wr_st & clr_word[`ST_ERASE_BIT]));
         xrst_seen_q  <= ~external_reset_line_lvl |
                         (xrst_seen_q & ~(wr_st & clr_word[`ST_XRST_BIT]));
      end
   end

   assign st_word = {25'h0000000, pin_lvl[6], external_reset_line_oe,
                     xrst_seen_q, erase_seen_q, fast_prog_mode,
                     boundary_scan_mode, swd_q};

endmodule // sysio_mux

// ---- sysio_props.sv ----
// Purpose: port checker for sysio_mux
// Assumes: slow clock period is SLOW_DIV aclk cycles
// Notes:   attached by the bind after the module
`timescale 1ns/10ps
module sysio_props #(
   parameter ERASE_TICKS = 4,
   parameter SLOW_DIV    = 10
) (
   input wire       aclk,
   input wire       aresetn,
   input wire [6:0] pad_in,
   input wire [6:0] pad_out,
   input wire [6:0] pad_oe,
   input wire [6:0] sys_out,
   input wire [6:0] sys_oe,
   input wire [6:0] pio_in,
   input wire       boundary_scan_mode,
   input wire       bscan_test_mode,
   input wire       fast_prog_mode,
   input wire       external_reset_line_in,
   input wire       external_reset_line_out,
   input wire       external_reset_line_oe,
   input wire       reset_ctrl_req,
   input wire       core_reset_n,
   input wire       flash_erase_start
);
   // ****************************************
   // cycles since the erase pin last rose
   // ****************************************
   reg [15:0] hi_q;
   reg        p6_q;
   always @(posedge aclk) begin
      p6_q <= pad_in[6];
      if (!aresetn || (pad_in[6] && !p6_q))
         hi_q <= 16'h0000;
      else if (hi_q != 16'hFFFF)
         hi_q <= hi_q + 16'h0001;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****************************************
   // properties
   // ****************************************
   property p_bscan_sys;
      boundary_scan_mode && $past(boundary_scan_mode) |->
         pad_oe[3:0] == $past(sys_oe[3:0]) && pad_out[3:0] == $past(sys_out[3:0]);
   endproperty
   a_bscan_sys: assert property (p_bscan_sys) else $error("debug pads not system driven");
   property p_fast;
      fast_prog_mode |-> !boundary_scan_mode && !bscan_test_mode;
   endproperty
   a_fast: assert property (p_fast) else $error("fast programming mixed with scan");
   property p_scan_test;
      bscan_test_mode |-> boundary_scan_mode;
   endproperty
   a_scan_test: assert property (p_scan_test) else $error("scan test without scan select");
   property p_drive_low;
      external_reset_line_oe |-> !external_reset_line_out;
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("reset line driven high");
   property p_req;
      reset_ctrl_req |=> external_reset_line_oe;
   endproperty
   a_req: assert property (p_req) else $error("reset request not driven out");
   property p_hold;
      $rose(external_reset_line_oe) |-> external_reset_line_oe[*8];
   endproperty
   a_hold: assert property (p_hold) else $error("outward reset pulse too short");
   property p_core_low;
      !external_reset_line_in[*7] |-> !core_reset_n;
   endproperty
   a_core_low: assert property (p_core_low) else $error("low reset line ignored");
   property p_core_high;
      external_reset_line_in[*7] |-> core_reset_n;
   endproperty
   a_core_high: assert property (p_core_high) else $error("core held in reset");
   property p_erase_len;
      flash_erase_start |-> hi_q >= ERASE_TICKS * SLOW_DIV;
   endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase on short high");
   property p_erase_once;
      flash_erase_start |=> !flash_erase_start;
   endproperty
   a_erase_once: assert property (p_erase_once) else $error("erase start repeated");
   property p_pio_in;
      $stable(pad_in)[*8] |-> pio_in == pad_in;
   endproperty
   a_pio_in: assert property (p_pio_in) else $error("port line input lost");
endmodule // sysio_props

bind sysio_mux sysio_props #(.ERASE_TICKS(ERASE_TICKS)) i_props (.aclk, .aresetn, .pad_in, .pad_out,
   .pad_oe, .sys_out, .sys_oe, .pio_in, .boundary_scan_mode, .bscan_test_mode, .fast_prog_mode,
   .external_reset_line_in, .external_reset_line_out, .external_reset_line_oe, .reset_ctrl_req,
   .core_reset_n, .flash_erase_start);

// ---- sysio_board.sv ----
// Purpose: board model: debug probe pads and external reset circuit
// Assumes: a pad the device drives wins over the probe
// Notes:   reset line has a pull-up, extra pull-down on command
`timescale 1ns/10ps
module sysio_board (
   input  wire [6:0] pad_out,
   input  wire [6:0] pad_oe,
   input  wire [6:0] ext_val,
   input  wire       rst_out,
   input  wire       rst_oe,
   input  wire       pull_low,
   output wire [6:0] pad_in,
   output wire       rst_level
);
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
   // open drain: either side pulls low, otherwise the pull-up wins
   assign rst_level = !((rst_oe && !rst_out) || pull_low);
endmodule // sysio_board

// ---- sysio_mux_tb.sv ----
// Purpose: self-checking bench for sysio_mux
// Assumes: short erase and reset counts set below
// Notes:   stimulus from a fixed-seed shift register
`timescale 1ns/10ps
`include "sysio_defs.vh"
module sysio_mux_tb;
   localparam LIMIT = 20000;
   reg         aclk = 0, aresetn = 0, slow_clock = 0;
   reg  [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   reg  [31:0] s_axi_wdata = 0;
   reg  [3:0]  s_axi_wstrb = 4'hF;
   reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   reg  [6:0]  sys_out = 0, sys_oe = 0, pio_out = 0, pio_oe = 0;
   reg  [6:0]  ext_val = 0; // erase line low from power-up
   reg         serial_wire_active = 0, async_trace_out = 0, boundary_scan_select = 0, test_mode_select = 0;
   reg         reset_ctrl_req = 0, pull_low = 0;
   wire [6:0]  pad_in, pad_out, pad_oe, pad_pull_up, pad_schmitt, pad_glitch, pad_debounce, sys_in, pio_in;
   wire        boundary_scan_mode, bscan_test_mode, fast_prog_mode, core_reset_n, flash_erase_start;
   wire        external_reset_line_in, external_reset_line_out, external_reset_line_oe;
   integer     failures = 0, n_checks = 0, cyc = 0, n_erase = 0, i;
   reg  [15:0] seed = 16'h000F;
   reg  [31:0] rd, s, p;
   reg  [1:0]  rs;

   sysio_mux #(.ERASE_TICKS(4), .EXTERNAL_RESET_LINE_CYC(20)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .pad_in, .pad_out, .pad_oe, .pad_pull_up, .pad_schmitt, .pad_glitch, .pad_debounce,
      .sys_out, .sys_oe, .sys_in, .serial_wire_active, .async_trace_out, .pio_out, .pio_oe, .pio_in,
      .boundary_scan_select, .test_mode_select, .boundary_scan_mode, .bscan_test_mode, .fast_prog_mode,
      .external_reset_line_in, .external_reset_line_out, .external_reset_line_oe, .reset_ctrl_req,
      .core_reset_n, .slow_clock, .flash_erase_start);
   sysio_board i_board (.pad_out, .pad_oe, .ext_val, .rst_out(external_reset_line_out),
      .rst_oe(external_reset_line_oe), .pull_low, .pad_in, .rst_level(external_reset_line_in));

   always #5 aclk = ~aclk;
   always #50 slow_clock = ~slow_clock;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (flash_erase_start === 1'b1) n_erase <= n_erase + 1;
      if (cyc == LIMIT) begin
         failures = failures + 1;
         stop_test;
      end
   end
   // ****************************************
   // helpers
   // ****************************************
   function [15:0] lfsr(input [15:0] v);
      integer k;
      begin
         lfsr = v;
         for (k = 0; k < 16; k = k + 1) lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
   endfunction
   function [6:0] selv(input [31:0] v);
      selv = {v[12], v[11], v[10], v[7], v[6], v[5], v[4]};
   endfunction
   task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wt(input integer n);
      repeat (n) @(posedge aclk);
   endtask
   // erase function is input only, so its drive bits stay clear
   task automatic rnd;
      seed = lfsr(seed);
      sys_out <= seed[6:0];
      sys_oe <= {1'b0, seed[12:7]};
      seed = lfsr(seed);
      pio_out <= seed[6:0];
      pio_oe <= seed[13:7];
      seed = lfsr(seed);
      ext_val <= {1'b0, seed[5:0]};
   endtask
   task automatic axw(input [5:0] a, input [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axr(input [5:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic pads(input [6:0] m);
      chk("pad_out", pad_out, (m & pio_out) | (~m & sys_out));
      chk("pad_oe", pad_oe, (m & pio_oe) | (~m & sys_oe));
      chk("sys_in", sys_in, ~m & pad_in);
      chk("pio_in", pio_in, pad_in);
   endtask
   task automatic erase_hold(input integer n, input integer exp);
      ext_val[6] <= 1'b1;
      wt(n);
      ext_val[6] <= 1'b0;
      wt(40);
      chk("erase_count", n_erase, exp);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      wt(10);
      aresetn <= 1'b1;
      axr(`SEL_OFS);
      chk("sel_reset", rd, 32'h0);
      axr(`PAD_OFS);
      chk("pad_reset", rd, 32'h0);
      axr(`STATUS_OFS);
      chk("swd_reset", rd[0], 1'b0);
      for (i = 0; i < 9; i = i + 1) begin
         s = (i < 7) ? 32'h1 << (i < 4 ? i + 4 : i + 6) : (i == 7 ? 32'h1CF0 : 32'h0);
         rnd;
         axw(`SEL_OFS, s);
         axr(`SEL_OFS);
         chk("sel", rd, s);
         wt(8);
         pads(selv(s));
      end
      $display("test mux done");
      seed = lfsr(seed);
      p = {4'h0, seed[11:0], seed};
      axw(`SEL_OFS, 32'h1CF0);
      axw(`PAD_OFS, p);
      wt(2);
      chk("pads_cfg", {pad_debounce, pad_glitch, pad_schmitt, pad_pull_up}, p[27:0]);
      axw(`SEL_OFS, 32'h0);
      wt(2);
      chk("pads_cfg_sys", {pad_debounce, pad_glitch, pad_schmitt, pad_pull_up}, p[27:0]);
      serial_wire_active <= 1'b1; // probe sent the switch sequence
      for (i = 0; i < 2; i = i + 1) begin
         async_trace_out <= i[0];
         wt(4);
         chk("trace", {pad_oe[1], pad_out[1]}, {1'b1, i[0]});
      end
      serial_wire_active <= 1'b0;
      wt(4);
      chk("tdo_jtag", {pad_oe[1], pad_out[1]}, {sys_oe[1], sys_out[1]});
      $display("test trace done");
      axw(`SEL_OFS, 32'h1CF0);
      for (i = 0; i < 4; i = i + 1) begin
         boundary_scan_select <= i[0];
         test_mode_select <= i[1];
         wt(8);
         chk("modes", {boundary_scan_mode, bscan_test_mode, fast_prog_mode}, {i[0], i[0] & i[1], ~i[0] & i[1]});
         chk("dbg_oe", pad_oe[3:0], i[0] ? sys_oe[3:0] : pio_oe[3:0]);
      end
      boundary_scan_select <= 1'b0;
      test_mode_select <= 1'b0;
      $display("test modes done");
      reset_ctrl_req <= 1'b1;
      wt(1);
      reset_ctrl_req <= 1'b0;
      wt(7);
      chk("rst_drive", {external_reset_line_oe, core_reset_n}, 2'b10);
      wt(30);
      chk("rst_release", {external_reset_line_oe, core_reset_n}, 2'b01);
      pull_low <= 1'b1;
      wt(8);
      chk("ext_rst", {external_reset_line_oe, core_reset_n}, 2'b00);
      pull_low <= 1'b0;
      wt(8);
      axw(`CTRL_OFS, 32'h1);
      axr(`STATUS_OFS);
      chk("rst_status", rd[5:4], 2'b11);
      $display("test reset done");
      axw(`SEL_OFS, 32'h0);
      wt(30);
      erase_hold(25, 0);
      erase_hold(90, 1);
      axr(`STATUS_OFS);
      chk("erase_seen", rd[3], 1'b1);
      pio_oe[6] <= 1'b0;
      axw(`SEL_OFS, 32'h1000);
      erase_hold(90, 1);
      $display("test erase done");
      axr(6'h10);
      chk("unmapped_rd", rd, 32'h0);
      chk("unmapped_rresp", rs, `AXI_SLVERR);
      axw(6'h14, 32'hFFFFFFFF);
      chk("unmapped_wr", rs, `AXI_SLVERR);
      $display("test bus done");
      stop_test;
   end
endmodule // sysio_mux_tb
